// File: rtl/crp_pkg.sv
// Shared constants, types and helpers of the processor register block.
package crp_pkg;

    // Timing: one basic pulse every 2.5 us, eight pulses to a word time.
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_NS = 2500;
    localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSES_PER_WORD = 8;

    // Pulse numbers inside a word time.
    localparam logic [2:0] PH_WDATA = 3'h1;
    localparam logic [2:0] PH_RDATA = 3'h3;
    localparam logic [2:0] PH_XFER = 3'h4;
    localparam logic [2:0] PH_ACT = 3'h5;
    localparam logic [2:0] PH_LAST = 3'(PULSES_PER_WORD - 1);

    // Instruction fields, vector bit 19 is the leftmost position 0.
    localparam int F_OP_HI = 19;
    localparam int F_OP_LO = 15;
    localparam int F_IX_HI = 14;
    localparam int F_IX_LO = 13;
    localparam int F_AD_HI = 12;
    localparam int SIGN = 19;

    // Operation codes.
    localparam logic [4:0] OP_HLT = 5'h00;
    localparam logic [4:0] OP_LDA = 5'h01;
    localparam logic [4:0] OP_STA = 5'h02;
    localparam logic [4:0] OP_ADD = 5'h03;
    localparam logic [4:0] OP_SUB = 5'h04;
    localparam logic [4:0] OP_MUL = 5'h05;
    localparam logic [4:0] OP_DIV = 5'h06;
    localparam logic [4:0] OP_LDQ = 5'h07;
    localparam logic [4:0] OP_LAQ = 5'h08;
    localparam logic [4:0] OP_BRU = 5'h09;
    localparam logic [4:0] OP_BPL = 5'h0a;
    localparam logic [4:0] OP_BMI = 5'h0b;
    localparam logic [4:0] OP_BZE = 5'h0c;
    localparam logic [4:0] OP_BOD = 5'h0d;
    localparam logic [4:0] OP_BEV = 5'h0e;
    localparam logic [4:0] OP_BPE = 5'h0f;
    localparam logic [4:0] OP_SDL = 5'h10;
    localparam logic [4:0] OP_SDR = 5'h11;
    localparam logic [4:0] OP_SNL = 5'h12;
    localparam logic [4:0] OP_SNR = 5'h13;
    localparam logic [4:0] OP_IEN = 5'h14;

    // Fixed core locations.
    localparam logic [12:0] INT_SAVE_ADDR = 13'h0004;
    localparam logic [12:0] INT_VEC_BASE = 13'h0010;

    // Register offsets on the bus.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_A = 8'h08;
    localparam logic [7:0] REG_Q = 8'h0c;
    localparam logic [7:0] REG_P = 8'h10;
    localparam logic [7:0] REG_I = 8'h14;
    localparam logic [7:0] REG_IRQ = 8'h18;
    localparam logic [7:0] REG_CHR = 8'h1c;

    // Control and status bit positions.
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_CLRPE = 2;
    localparam int CTRL_CLROV = 3;
    localparam int ST_RUN = 0;
    localparam int ST_PERR = 1;
    localparam int ST_OVF = 2;
    localparam int ST_IEN = 4;

    typedef enum logic [5:0] {
        S_HALT = 6'b000001,
        S_FETCH = 6'b000010,
        S_INDEX = 6'b000100,
        S_OPER = 6'b001000,
        S_EXEC = 6'b010000,
        S_INTSV = 6'b100000
    } crp_state_t;

    typedef struct packed {
        logic we;
        logic [12:0] addr;
        logic [20:0] wdata;
    } crp_mem_req_t;

    typedef struct packed {
        logic [19:0] a;
        logic [19:0] i;
        logic [12:0] p;
        logic par;
        logic ovf;
        logic run;
    } crp_lamps_t;

    // Odd parity: the extra bit is one when the data holds an even count of ones.
    function automatic logic par_bit(input logic [19:0] d);
        return ~(^d);
    endfunction

endpackage

// File: rtl/crp_core.sv
// Processor registers, word timing, parity, indexing and priority interrupt.
`timescale 1ns/100ps
`default_nettype none
module crp_core
    import crp_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int NDEV = 2
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core memory and arbitration.
    output crp_mem_req_t mem_o,
    input wire logic [20:0] mem_rdata_i,
    input wire logic [NDEV-1:0] dev_req_i,
    output logic [NDEV-1:0] dev_gnt_o,
    output logic cpu_gnt_o,
    // Console.
    input wire logic [19:0] sw_i,
    input wire logic sw_load_i,
    input wire logic sw_halt_par_i,
    output crp_lamps_t lamps_o,
    // Interrupt inputs.
    input wire logic [11:0] irq_i
);

    localparam int DW = $clog2(PULSE_CYCLES);

    crp_state_t st, next_st;
    logic [DW-1:0] div;
    logic [2:0] ph;
    logic pulse, word_end, act, own, rd_word;
    logic [19:0] sw_s1, sw_s2;
    logic [2:0] ld_s;
    logic [1:0] hp_s;
    logic [11:0] irq_s1, irq_s2, irq_s3;
    logic [19:0] a, q, b, ireg;
    logic [6:0] chr;
    logic [12:0] p;
    logic [20:0] z;
    logic ovf, perr, perr_word, mem_we;
    logic [12:0] mem_addr;
    logic [11:0] pend;
    logic [1:0] ien;
    logic [3:0] irq_sel;
    logic start_req, stop_req, ack;
    logic wr, rd, ld_pulse, irq_take, to_halt;
    logic [4:0] op;
    logic [1:0] ix;
    logic [12:0] iadr;
    logic [11:0] ien_mask, live;
    logic [46:0] sh;
    logic [37:0] prod, dvd, quo, rem;
    logic [31:0] p_mrg, chr_mrg;
    logic [20:0] sum_r, dif_r;
    logic clr_ov;

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int k = 0; k < 4; k++) begin
            if (s[k]) begin
                r[8*k +: 8] = n[8*k +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [20:0] addsub(input logic [19:0] x, input logic [19:0] y, input logic sub);
        logic [19:0] yy, s;
        yy = sub ? ~y : y;
        s = x + yy + {19'h00000, sub};
        return {(x[SIGN] == yy[SIGN]) && (s[SIGN] != x[SIGN]), s};
    endfunction

    function automatic logic [3:0] pick(input logic [11:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 11; k >= 0; k--) begin
            if (v[k]) begin
                r = 4'(k);
            end
        end
        return r;
    endfunction

    function automatic logic needs_mem(input crp_state_t s);
        return s inside {S_FETCH, S_INDEX, S_OPER, S_INTSV};
    endfunction

    assign op = ireg[F_OP_HI:F_OP_LO];
    assign ix = ireg[F_IX_HI:F_IX_LO];
    assign iadr = ireg[F_AD_HI:0];
    assign pulse = div == DW'(PULSE_CYCLES - 1);
    assign word_end = pulse && (ph == PH_LAST);
    assign act = pulse && (ph == PH_ACT);
    assign rd_word = own && (st inside {S_FETCH, S_INDEX}
        || (st == S_OPER && op != OP_STA));
    assign ld_pulse = ld_s[1] && !ld_s[2];
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack;
    // Level one is bits 3:0, so enabling a level also enables all below it.
    assign ien_mask = {{4{ien == 2'h3}}, {4{ien >= 2'h2}}, {4{ien != 2'h0}}};
    assign live = pend & ien_mask;
    assign irq_take = |live;
    assign to_halt = stop_req || (perr_word && hp_s[1]);
    assign sh = (op inside {OP_SNL, OP_SNR}) ? {chr, a, q} : {7'h00, a, q};
    assign prod = a[18:0] * b[18:0];
    assign dvd = {a[18:0], q[18:0]};
    assign quo = dvd / {19'h00000, b[18:0]};
    assign rem = dvd % {19'h00000, b[18:0]};
    assign p_mrg = wmerge({19'h00000, p}, wb_dat_i, wb_sel_i);
    assign chr_mrg = wmerge({25'h0000000, chr}, wb_dat_i, wb_sel_i);
    assign sum_r = addsub(a, b, 1'b0);
    assign dif_r = addsub(a, b, 1'b1);
    assign clr_ov = wr && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_CLROV];

    assign wb_ack_o = ack;
    assign mem_o = '{we: mem_we, addr: mem_addr, wdata: z};
    assign cpu_gnt_o = own;
    assign lamps_o = '{a: a, i: ireg, p: p, par: perr, ovf: ovf, run: st != S_HALT};

    // Console and interrupt pins are resynchronised before use.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_s1 <= 20'h00000;
            sw_s2 <= 20'h00000;
            ld_s <= 3'h0;
            hp_s <= 2'h0;
            irq_s1 <= 12'h000;
            irq_s2 <= 12'h000;
            irq_s3 <= 12'h000;
        end else begin
            sw_s1 <= sw_i;
            sw_s2 <= sw_s1;
            ld_s <= {ld_s[1:0], sw_load_i};
            hp_s <= {hp_s[0], sw_halt_par_i};
            irq_s1 <= irq_i;
            irq_s2 <= irq_s1;
            irq_s3 <= irq_s2;
        end
    end

    // Pulse divider and pulse counter within the word.
    always_ff @(posedge clk_i) begin
        if (rst_i || pulse) begin
            div <= '0;
        end else begin
            div <= div + DW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph <= 3'h0;
        end else if (pulse) begin
            ph <= ph + 3'h1;
        end
    end

    // Sequencing decided at word boundaries. A word without the memory grant repeats.
    always_comb begin
        next_st = st;
        unique case (st)
            S_HALT: begin
                next_st = start_req ? S_FETCH : S_HALT;
            end
            S_FETCH: begin
                if (own) begin
                    next_st = (ix != 2'h0) ? S_INDEX
                        : (op inside {OP_LDA, OP_STA, OP_ADD, OP_SUB, OP_MUL, OP_DIV}) ? S_OPER : S_EXEC;
                end
            end
            S_INDEX: begin
                if (own) begin
                    next_st = (op inside {OP_LDA, OP_STA, OP_ADD, OP_SUB, OP_MUL, OP_DIV}) ? S_OPER : S_EXEC;
                end
            end
            S_OPER: begin
                if (own) begin
                    next_st = (op inside {OP_MUL, OP_DIV}) ? S_EXEC : S_FETCH;
                end
            end
            S_EXEC: begin
                next_st = (op == OP_HLT) ? S_HALT : S_FETCH;
            end
            S_INTSV: begin
                if (own) begin
                    next_st = S_FETCH;
                end
            end
        endcase
        // Interrupts are looked at only where the next instruction would be fetched.
        if (next_st == S_FETCH && st != S_FETCH) begin
            if (to_halt && st != S_HALT) begin
                next_st = S_HALT;
            end else if (irq_take) begin
                next_st = S_INTSV;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= S_HALT;
            irq_sel <= 4'h0;
        end else if (word_end) begin
            st <= next_st;
            irq_sel <= pick(live);
        end
    end

    // One owner per word; any requesting device beats the processor.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            own <= 1'b0;
            dev_gnt_o <= '0;
            mem_we <= 1'b0;
            mem_addr <= 13'h0000;
        end else if (word_end) begin
            dev_gnt_o <= dev_req_i & (~dev_req_i + NDEV'(1));
            own <= !(|dev_req_i) && needs_mem(next_st);
            mem_we <= !(|dev_req_i) && (next_st == S_INTSV || (next_st == S_OPER && op == OP_STA));
            unique case (next_st)
                S_FETCH: mem_addr <= p;
                S_INDEX: mem_addr <= {11'h000, ix};
                S_INTSV: mem_addr <= INT_SAVE_ADDR;
                default: mem_addr <= iadr;
            endcase
        end
    end

    // Memory buffer: parity on the way out, parity check on the way in.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            z <= 21'h000000;
            perr_word <= 1'b0;
        end else if (pulse) begin
            if (ph == PH_WDATA && mem_we && own) begin
                z <= (st == S_INTSV) ? {par_bit({7'h00, p}), 7'h00, p} : {par_bit(a), a};
            end
            if (ph == PH_RDATA && rd_word) begin
                z <= mem_rdata_i;
                perr_word <= !(^mem_rdata_i);
            end
            if (ph == PH_LAST) begin
                perr_word <= 1'b0;
            end
        end
    end

    // The lamp flag is sticky; a new error wins over a clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            perr <= 1'b0;
        end else if (pulse && ph == PH_RDATA && rd_word && !(^mem_rdata_i)) begin
            perr <= 1'b1;
        end else if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_CLRPE]) begin
            perr <= 1'b0;
        end
    end

    // Operand buffer decouples the arithmetic from memory during long operations.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            b <= 20'h00000;
        end else if (pulse && ph == PH_XFER && rd_word) begin
            b <= z[19:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ireg <= 20'h00000;
        end else if (act && own && st == S_FETCH) begin
            ireg <= b;
        end else if (act && own && st == S_INDEX) begin
            ireg[F_AD_HI:0] <= iadr + b[F_AD_HI:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            p <= 13'h0000;
        end else if (st == S_HALT && wr && wb_adr_i == REG_P) begin
            p <= p_mrg[12:0];
        end else if (act && own && st == S_FETCH) begin
            p <= p + 13'h0001;
        end else if (act && own && st == S_INTSV) begin
            p <= INT_VEC_BASE + {9'h000, irq_sel};
        end else if (act && st == S_EXEC) begin
            unique case (op)
                OP_BRU: p <= iadr;
                OP_BPL: p <= (!a[SIGN] && a != 20'h00000) ? iadr : p;
                OP_BMI: p <= a[SIGN] ? iadr : p;
                OP_BZE: p <= (a == 20'h00000) ? iadr : p;
                OP_BOD: p <= a[0] ? iadr : p;
                OP_BEV: p <= !a[0] ? iadr : p;
                OP_BPE: p <= perr ? iadr : p;
                default: p <= p;
            endcase
        end
    end

    // Arithmetic registers. Add and subtract are two's complement; multiply and
    // divide work on sign and 19-bit magnitude, giving a 38-bit double plus sign.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a <= 20'h00000;
            q <= 20'h00000;
            chr <= 7'h00;
            ovf <= 1'b0;
        end else begin
            if (st == S_HALT && ld_pulse) begin
                a <= sw_s2;
            end
            if (wr && wb_adr_i == REG_CHR) begin
                chr <= chr_mrg[6:0];
            end
            if (clr_ov) begin
                ovf <= 1'b0;
            end
            if (act && own && st == S_OPER) begin
                unique case (op)
                    OP_LDA: a <= b;
                    OP_ADD: {ovf, a} <= {(ovf && !clr_ov) | sum_r[20], sum_r[19:0]};
                    OP_SUB: {ovf, a} <= {(ovf && !clr_ov) | dif_r[20], dif_r[19:0]};
                    default: a <= a;
                endcase
            end
            if (act && st == S_EXEC) begin
                unique case (op)
                    OP_LDQ: q <= a;
                    OP_LAQ: a <= q;
                    OP_MUL: begin
                        a <= {a[SIGN] ^ b[SIGN], prod[37:19]};
                        q <= {1'b0, prod[18:0]};
                    end
                    OP_DIV: begin
                        // A quotient that cannot fit, divide by zero included, leaves A and Q.
                        if (a[18:0] >= b[18:0]) begin
                            ovf <= 1'b1;
                        end else begin
                            a <= {a[SIGN] ^ b[SIGN], quo[18:0]};
                            q <= {a[SIGN], rem[18:0]};
                        end
                    end
                    OP_SDL: {a, q} <= sh[39:0] << iadr[4:0];
                    OP_SDR: {a, q} <= sh[39:0] >> iadr[4:0];
                    OP_SNL: {chr, a, q} <= sh << iadr[4:0];
                    OP_SNR: {chr, a, q} <= sh >> iadr[4:0];
                    default: a <= a;
                endcase
            end
        end
    end

    // Requests latch on a rising input; a new request wins over any clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend <= 12'h000;
        end else begin
            pend <= (pend & ~((wr && wb_adr_i == REG_IRQ) ? wb_dat_i[11:0] : 12'h000)
                & ~((act && own && st == S_INTSV) ? (12'h001 << irq_sel) : 12'h000))
                | (irq_s2 & ~irq_s3);
        end
    end

    // Entry to a service routine drops the enable so the routine is not re-entered.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ien <= 2'h0;
        end else if (act && own && st == S_INTSV) begin
            ien <= 2'h0;
        end else if (act && st == S_EXEC && op == OP_IEN) begin
            ien <= iadr[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_req <= 1'b0;
            stop_req <= 1'b0;
        end else begin
            if (word_end && st == S_HALT) begin
                start_req <= 1'b0;
            end
            if (word_end && next_st == S_HALT) begin
                stop_req <= 1'b0;
            end
            if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
                start_req <= start_req | wb_dat_i[CTRL_START];
                stop_req <= stop_req | wb_dat_i[CTRL_STOP];
            end
        end
    end

    // Bus answer one cycle after the request; unmapped reads give zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            ack <= wb_cyc_i && wb_stb_i && !ack;
            if (rd) begin
                unique case (wb_adr_i)
                    REG_STAT: wb_dat_o <= {26'h0000000, ien, 1'b0, ovf, perr, st != S_HALT};
                    REG_A: wb_dat_o <= {12'h000, a};
                    REG_Q: wb_dat_o <= {12'h000, q};
                    REG_P: wb_dat_o <= {19'h00000, p};
                    REG_I: wb_dat_o <= {12'h000, ireg};
                    REG_IRQ: wb_dat_o <= {20'h00000, pend};
                    REG_CHR: wb_dat_o <= {25'h0000000, chr};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// File: test/crp_checker.sv
// Port assertions for the processor register block.
`timescale 1ns/100ps
`default_nettype none
module crp_checker
    import crp_pkg::*;
#(
    parameter int PULSE_CYCLES = 2,
    parameter int NDEV = 2
) (
    // Clock, reset and bus handshake.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Memory, grants and lamps.
    input wire crp_mem_req_t mem_o,
    input wire logic [NDEV-1:0] dev_req_i,
    input wire logic [NDEV-1:0] dev_gnt_o,
    input wire logic cpu_gnt_o,
    input wire crp_lamps_t lamps_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing wrong");
    property p_owner; $onehot0({dev_gnt_o, cpu_gnt_o}); endproperty
    a_owner: assert property (p_owner) else $error("two memory owners");
    property p_cpu_last; $rose(cpu_gnt_o) |-> $past(dev_req_i) == '0; endproperty
    a_cpu_last: assert property (p_cpu_last) else $error("processor beat a device");
    property p_dev_ord; $rose(dev_gnt_o[1]) |-> !$past(dev_req_i[0]); endproperty
    a_dev_ord: assert property (p_dev_ord) else $error("device order wrong");
    property p_hold; $rose(cpu_gnt_o) |=> (cpu_gnt_o && $stable(mem_o.addr))[*7]; endproperty
    a_hold: assert property (p_hold) else $error("processor word cut short");
    property p_dev_hold; $rose(dev_gnt_o[0]) |=> dev_gnt_o[0][*7]; endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("device word cut short");
    property p_par;
        cpu_gnt_o && mem_o.we && $changed(mem_o.wdata) |-> mem_o.wdata[20] == ~(^mem_o.wdata[19:0]);
    endproperty
    a_par: assert property (p_par) else $error("write parity wrong");
    property p_halt_p;
        !lamps_o.run && !$past(lamps_o.run) && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) |-> $stable(lamps_o.p);
    endproperty
    a_halt_p: assert property (p_halt_p) else $error("counter moved while halted");
    c_write: cover property (cpu_gnt_o && mem_o.we);
    c_dev: cover property ($rose(dev_gnt_o[1]));
    c_perr: cover property ($rose(lamps_o.par));
endmodule
bind crp_core crp_checker #(.PULSE_CYCLES(PULSE_CYCLES), .NDEV(NDEV)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .mem_o(mem_o), .dev_req_i(dev_req_i),
    .dev_gnt_o(dev_gnt_o), .cpu_gnt_o(cpu_gnt_o), .lamps_o(lamps_o));
`default_nettype wire

// File: test/crp_mem_model.sv
// Core memory model holding 21-bit words for the processor.
`timescale 1ns/100ps
`default_nettype none
module crp_mem_model
    import crp_pkg::*;
(
    // Clock, request and read word.
    input wire logic clk_i,
    input wire crp_mem_req_t mem_i,
    input wire logic gnt_i,
    output logic [20:0] rdata_o
);
    logic [20:0] mem [8192];
    logic tog = 1'b0;
    always @(posedge clk_i) begin
        tog <= ~tog;
        if (gnt_i && mem_i.we) begin
            mem[mem_i.addr] <= mem_i.wdata;
        end
    end
    // Outside its own read word the lines toggle, so a late sample cannot pass.
    assign rdata_o = (gnt_i && !mem_i.we) ? mem[mem_i.addr] : {21{tog}};
    // Preloads a word; a set flag stores it with the wrong parity.
    task automatic put(input logic [12:0] a, input logic [19:0] d, input logic bad);
        mem[a] = {~(^d) ^ bad, d};
    endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the processor register block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin num_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module testbench
    import crp_pkg::*;
();
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, gnt, ld = 1'b0, hp = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdo, rd;
    logic [1:0] dreq = 2'h0;
    logic [19:0] sw = 20'h0, x, y;
    logic [19:0] pg[$], dq[$];
    logic [20:0] rdat;
    logic [11:0] irq = 12'h000;
    crp_mem_req_t mem;
    crp_lamps_t lamps;
    int num_errors = 0;
    int n_tests = 0;
    crp_core #(.PULSE_CYCLES(2), .NDEV(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdo),
        .wb_ack_o(ack), .mem_o(mem), .mem_rdata_i(rdat), .dev_req_i(dreq), .dev_gnt_o(),
        .cpu_gnt_o(gnt), .sw_i(sw), .sw_load_i(ld), .sw_halt_par_i(hp), .lamps_o(lamps), .irq_i(irq));
    crp_mem_model mem_u (.clk_i(clk_i), .mem_i(mem), .gnt_i(gnt), .rdata_o(rdat));
    initial forever #5 clk_i = ~clk_i;
    // Other memory users steal words now and then, so the processor must wait its turn.
    always @(posedge clk_i) dreq <= ($urandom % 16 == 0) ? 2'($urandom) : 2'h0;
    function automatic logic [19:0] ins(input logic [4:0] op, input int ix, input int ad);
        return {op, 2'(ix), 13'(ad)};
    endfunction
    function automatic logic [20:0] pw(input logic [19:0] d);
        return {~(^d), d};
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rd = rdo;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
        if (n >= 40) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic wait_run(input logic lvl);
        int n;
        n = 0;
        while (lamps.run !== lvl) begin
            @(posedge clk_i);
            n++;
            if (n > 3000) begin
                num_errors++;
                conclude();
            end
        end
    endtask
    task automatic run(input logic [12:0] p);
        foreach (pg[i]) mem_u.put(p + 13'(i), pg[i], 1'b0);
        wb(1'b1, REG_P, 32'(p));
        wb(1'b1, REG_CTRL, 32'h1);
        wait_run(1'b1);
    endtask
    initial begin
        void'($urandom(94245));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        x = 20'($urandom % 32'h1ffff) + 20'h1;
        y = 20'($urandom % 32'h20000);
        dq = '{x, y, 0, 3, 5, 0, 0, 4};
        foreach (dq[i]) mem_u.put(13'h80 + 13'(i), dq[i], 1'b0);
        mem_u.put(13'h1, 20'h1, 1'b0);
        pg = '{ins(OP_LDA, 0, 'h80), ins(OP_ADD, 0, 'h81), ins(OP_STA, 0, 'h82), ins(OP_SUB, 1, 'h80),
            ins(OP_STA, 0, 'h88), ins(OP_BPL, 0, 'h47), ins(OP_HLT, 0, 0), ins(OP_LDA, 0, 'h83),
            ins(OP_MUL, 0, 'h84), ins(OP_LAQ, 0, 0), ins(OP_STA, 0, 'h85), ins(OP_LDA, 0, 'h86),
            ins(OP_DIV, 0, 'h87), ins(OP_HLT, 0, 0)};
        run(13'h40);
        wait_run(1'b0);
        wb(1'b0, REG_A, 32'h0);
        `CHK("A", 20'h3, rd[19:0])
        wb(1'b0, REG_Q, 32'h0);
        `CHK("Q", 20'h3, rd[19:0])
        `CHK("P", 13'h4e, lamps.p)
        `CHK("sum", pw(x + y), mem_u.mem[13'h82])
        `CHK("index", pw(x), mem_u.mem[13'h88])
        `CHK("product", pw(20'hf), mem_u.mem[13'h85])
        $display("test program done");
        mem_u.put(13'h90, x, 1'b1);
        pg = '{ins(OP_LDA, 0, 'h90), ins(OP_BPE, 0, 'h53), ins(OP_HLT, 0, 0), ins(OP_HLT, 0, 0)};
        run(13'h50);
        wait_run(1'b0);
        `CHK("perr", 1'b1, lamps.par)
        `CHK("P", 13'h54, lamps.p)
        wb(1'b1, REG_CTRL, 32'h4);
        `CHK("pclr", 1'b0, lamps.par)
        hp <= 1'b1;
        run(13'h50);
        wait_run(1'b0);
        `CHK("P", 13'h51, lamps.p)
        hp <= 1'b0;
        $display("test parity done");
        for (int v = 0; v < 12; v++) mem_u.put(INT_VEC_BASE + 13'(v), ins(OP_HLT, 0, 0), 1'b0);
        pg = '{ins(OP_IEN, 0, 2), ins(OP_BRU, 0, 'h61)};
        run(13'h60);
        irq <= 12'h200;
        repeat (200) @(posedge clk_i);
        irq <= 12'h242;
        wait_run(1'b0);
        `CHK("P", INT_VEC_BASE + 13'h2, lamps.p)
        `CHK("saved", 13'h61, mem_u.mem[INT_SAVE_ADDR][12:0])
        wb(1'b0, REG_IRQ, 32'h0);
        `CHK("pending", 12'h240, rd[11:0])
        wb(1'b1, REG_IRQ, 32'hfff);
        irq <= 12'h000;
        $display("test interrupt done");
        sw <= 20'($urandom);
        repeat (4) @(posedge clk_i);
        ld <= 1'b1;
        repeat (6) @(posedge clk_i);
        ld <= 1'b0;
        wb(1'b0, REG_A, 32'h0);
        `CHK("switch", sw, rd[19:0])
        wb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        $display("test console done");
        pg = '{ins(OP_LDA, 0, 'h83), ins(OP_LDQ, 0, 0), ins(OP_SDL, 0, 4), ins(OP_BEV, 0, 'h75), ins(OP_HLT, 0, 0),
            ins(OP_SDR, 0, 8), ins(OP_BZE, 0, 'h78), ins(OP_HLT, 0, 0), ins(OP_HLT, 0, 0)};
        run(13'h70);
        wait_run(1'b0);
        wb(1'b0, REG_Q, 32'h0);
        `CHK("shift", 20'h30000, rd[19:0])
        `CHK("P", 13'h79, lamps.p)
        wb(1'b0, REG_STAT, 32'h0);
        `CHK("stat", 32'h2, rd)
        $display("test shift done");
        conclude();
    end
endmodule
`default_nettype wire
